// [verilog/ctl_port_core.sv]
// Control port slave: address decode, control words, status and item handshakes.
// Assumes the decoder core on clk_i supplies lock, subprocess, frame and item data.
`timescale 1ns/1ps

module ctl_port_core (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Serial control bus
  input wire logic ctl_bit_clock_i,
  input wire logic ctl_addr_data_select_i,
  input wire logic ctl_serial_data_i,
  output logic ctl_serial_data_o,
  output logic ctl_serial_data_oe_o,
  // Decoder state
  input wire logic input_locked_i,
  input wire logic [1:0] subprocess_i,
  input wire logic frame_start_i,
  // Item data side
  input wire logic [7:0] item_rd_data_i,
  input wire logic item_ack_i,
  output logic item_start_o,
  output logic item_cont_o,
  output logic [7:0] item_code_o,
  output logic item_wr_o,
  output logic [7:0] item_wr_data_o,
  output logic item_rd_o,
  // Visible state
  output logic [7:0] control_word_o,
  output ctl_port_pkg::status_t status_word_o,
  output logic port_ready_o,
  output ctl_port_pkg::valid_t item_valid_o
);

  typedef struct packed {
    logic [1:0] clk_s;
    logic [1:0] sel_s;
    logic [1:0] tog_s;
    logic clk_p;
    logic sel_p;
    logic tog_p;
    ctl_port_pkg::init_t init;
    logic link_clr;
    logic addressed;
    ctl_port_pkg::mode_t mode;
    logic [7:0] ctrl;
    logic ctrl_seen;
    logic ready;
    logic [7:0] item_code;
    logic [7:0] saved_code;
    logic frame_tog;
    logic [7:0] tx;
    logic [2:0] txcnt;
    logic sd;
    logic sd_oe;
    logic item_start;
    logic item_cont;
    logic item_wr;
    logic item_rd;
    logic [7:0] wr_data;
    ctl_port_pkg::status_t status;
    ctl_port_pkg::valid_t valid;
  } core_t;

  core_t q;
  core_t d;
  ctl_port_pkg::link_byte_t rx_byte;
  logic rx_toggle;
  logic byte_ev;
  logic sel_edge;
  logic clk_rise;
  logic rd_mode;
  logic drive;
  logic run;
  ctl_port_pkg::status_t status_now;
  logic [7:0] load_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain receiver.
  ctl_link_rx ctl_link_rx_inst (
    .link_clk_i(ctl_bit_clock_i),
    .link_clr_i(q.link_clr),
    .sd_i(ctl_serial_data_i),
    .sel_i(ctl_addr_data_select_i),
    .byte_o(rx_byte),
    .toggle_o(rx_toggle)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Events seen after synchronisation.
  assign byte_ev = q.tog_s[1] ^ q.tog_p;
  assign sel_edge = q.sel_s[1] ^ q.sel_p;
  assign clk_rise = q.clk_s[1] & ~q.clk_p;
  assign run = (q.init == ctl_port_pkg::INIT_RUN);
  // An item read before any control word is refused, so the line stays free.
  assign rd_mode = q.addressed && (q.mode == ctl_port_pkg::MODE_RD_STAT ||
    (q.mode == ctl_port_pkg::MODE_RD_ITEM && q.ctrl_seen)); // R9
  assign drive = rd_mode && q.sel_s[1] && run; // R24

  // Decode state is masked while unlocked so stale phases never reach the host.
  always_comb begin
    status_now = '0;
    status_now.port_ready = q.ready; // R14
    status_now.input_locked = input_locked_i; // R14
    if (input_locked_i) begin
      status_now.frame_toggle = q.frame_tog; // R15
      status_now.subprocess = subprocess_i; // R16 R17
    end
  end

  assign load_byte = (q.mode == ctl_port_pkg::MODE_RD_STAT) ? status_now : item_rd_data_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    d = q;
    d.clk_s = {q.clk_s[0], ctl_bit_clock_i};
    d.sel_s = {q.sel_s[0], ctl_addr_data_select_i};
    d.tog_s = {q.tog_s[0], rx_toggle};
    d.clk_p = q.clk_s[1];
    d.sel_p = q.sel_s[1];
    d.tog_p = q.tog_s[1];
    // A clear also zeroes the link toggle; follow it here so that no false byte appears.
    if (q.link_clr) begin
      d.tog_s = 2'h0;
      d.tog_p = 1'b0;
    end
    d.item_start = 1'b0;
    d.item_cont = 1'b0;
    d.item_wr = 1'b0;
    d.item_rd = 1'b0;

    // The port stays deaf until the select pulse, since bytes before it
    // would be misaligned.
    unique case (q.init)
      ctl_port_pkg::INIT_WAIT_HI: begin
        if (q.sel_s[1] && q.clk_s[1]) begin
          d.init = ctl_port_pkg::INIT_WAIT_LO; // R8
        end
      end
      ctl_port_pkg::INIT_WAIT_LO: begin
        if (!q.sel_s[1] && q.clk_s[1]) begin
          d.init = ctl_port_pkg::INIT_RUN; // R8 R23
        end
      end
      ctl_port_pkg::INIT_RUN: begin
      end
    endcase

    // Each select edge restarts the bit count in the link domain.
    d.link_clr = !run || sel_edge; // R7

    if (byte_ev && run) begin
      if (!rx_byte.sel) begin
        d.addressed = (rx_byte.data[7:2] == ctl_port_pkg::DEV_ADDR_PATTERN); // R1 R3
        d.mode = ctl_port_pkg::mode_t'(rx_byte.data[1:0]); // R4
      end else if (q.addressed) begin // R2
        unique case (q.mode)
          ctl_port_pkg::MODE_WR_CTRL: begin
            d.ctrl = rx_byte.data; // R10
            d.ctrl_seen = 1'b1;
            if (rx_byte.data == ctl_port_pkg::CODE_CONTINUE) begin
              d.item_code = q.saved_code; // R12
              d.item_cont = 1'b1;
              d.ready = 1'b1; // R18
            end else if (rx_byte.data <= ctl_port_pkg::CODE_COEF_WRITE &&
                rx_byte.data != ctl_port_pkg::CODE_RESERVED) begin // R11
              if (rx_byte.data == ctl_port_pkg::CODE_COEF_WRITE &&
                  q.item_code != ctl_port_pkg::CODE_COEF_WRITE) begin
                d.saved_code = q.item_code; // R12
              end
              d.item_code = rx_byte.data;
              d.item_start = 1'b1; // R5
              d.ready = 1'b1; // R18
            end
          end
          ctl_port_pkg::MODE_WR_ITEM: begin
            if (q.ctrl_seen) begin // R9
              d.item_wr = 1'b1; // R5
              d.wr_data = rx_byte.data;
              if (q.item_code != ctl_port_pkg::CODE_COEF_WRITE) begin
                d.ready = 1'b0; // R6
              end
            end
          end
          ctl_port_pkg::MODE_RD_ITEM: begin
          end
          ctl_port_pkg::MODE_RD_STAT: begin
          end
        endcase
      end
    end

    // Transmit runs on the oversampled bit clock: a bit changes a few cycles
    // after the rising edge on which the host sampled the previous one.
    if (!drive) begin
      d.tx = load_byte;
      d.txcnt = 3'h0;
    end else if (clk_rise) begin
      if (q.txcnt == ctl_port_pkg::LAST_BIT) begin
        d.tx = load_byte; // R13
        d.txcnt = 3'h0;
        if (q.mode == ctl_port_pkg::MODE_RD_ITEM) begin
          d.item_rd = 1'b1; // R5
          if (q.item_code != ctl_port_pkg::CODE_COEF_WRITE) begin
            d.ready = 1'b0; // R6
          end
        end
      end else begin
        d.tx = {1'b0, q.tx[7:1]};
        d.txcnt = q.txcnt + 3'h1;
      end
    end else if (q.mode == ctl_port_pkg::MODE_RD_STAT && q.txcnt == 3'h0) begin
      // Before clocking starts the line follows the ready flag live.
      d.tx = status_now; // R19
    end

    // A completion arriving with a byte end still sets ready.
    if (item_ack_i && q.ctrl_seen) begin
      d.ready = 1'b1; // R6
    end

    if (frame_start_i) begin
      d.frame_tog = ~q.frame_tog; // R15
    end

    d.sd = d.tx[0];
    d.sd_oe = drive; // R24
    d.status = status_now; // R14
    d.valid.anc = input_locked_i && (subprocess_i != ctl_port_pkg::SUB_HEADER); // R20
    d.valid.hdr = input_locked_i && (subprocess_i != ctl_port_pkg::SUB_HEADER); // R20
    d.valid.alloc_ok = input_locked_i && (subprocess_i != ctl_port_pkg::SUB_ALLOC); // R21
    d.valid.decode_fail = input_locked_i && (subprocess_i == ctl_port_pkg::SUB_SAMPLES ||
      subprocess_i == ctl_port_pkg::SUB_HEADER); // R22

    if (!ce_i) begin
      d = q;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      // The bit clock idles high, so a zero here would fake a rising edge.
      q.clk_s <= {2{ctl_port_pkg::BIT_CLK_IDLE}};
      q.clk_p <= ctl_port_pkg::BIT_CLK_IDLE;
      q.init <= ctl_port_pkg::INIT_WAIT_HI;
      q.link_clr <= 1'b1; // R7
      q.ctrl <= ctl_port_pkg::CTRL_RESET;
      q.mode <= ctl_port_pkg::MODE_WR_ITEM;
      q.ready <= 1'b0; // R18
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign ctl_serial_data_o = q.sd;
  assign ctl_serial_data_oe_o = q.sd_oe;
  assign item_start_o = q.item_start;
  assign item_cont_o = q.item_cont;
  assign item_code_o = q.item_code;
  assign item_wr_o = q.item_wr;
  assign item_wr_data_o = q.wr_data;
  assign item_rd_o = q.item_rd;
  assign control_word_o = q.ctrl;
  assign status_word_o = q.status;
  assign port_ready_o = q.ready;
  assign item_valid_o = q.valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_ready_after_ctrl: assert property (!q.ctrl_seen |-> !q.ready) // R18
    else $error("port ready set before first control word");

  chk_line_quiet: assert property (ctl_serial_data_oe_o |-> // R24
    $past(q.addressed) && $past(q.sel_s[1]) && $past(run))
    else $error("data line driven while not selected for read");

  chk_init_hold: assert property (!run |-> q.link_clr && !ctl_serial_data_oe_o) // R7
    else $error("port active before initialisation");

  chk_addr_decode: assert property (byte_ev && run && ce_i && !rx_byte.sel && // R3
    rx_byte.data[7:2] == ctl_port_pkg::DEV_ADDR_PATTERN |=>
    q.addressed && q.mode == $past(rx_byte.data[1:0]))
    else $error("own address not taken");

  chk_ctrl_replace: assert property (byte_ev && run && ce_i && rx_byte.sel && // R10
    q.addressed && q.mode == ctl_port_pkg::MODE_WR_CTRL |=>
    control_word_o == $past(rx_byte.data))
    else $error("control word not replaced");

  chk_code_legal: assert property (item_start_o |-> // R11
    item_code_o <= ctl_port_pkg::CODE_COEF_WRITE &&
    item_code_o != ctl_port_pkg::CODE_RESERVED)
    else $error("item started by a reserved code");

  chk_continue_resume: assert property (item_cont_o |-> // R12
    item_code_o == q.saved_code && port_ready_o)
    else $error("continue did not resume saved item");

  chk_no_early_item: assert property (!q.ctrl_seen |-> !q.item_wr && !q.item_rd) // R9
    else $error("item byte before first control word");

  chk_frame_toggle: assert property (frame_start_i && ce_i |=> // R15
    q.frame_tog != $past(q.frame_tog))
    else $error("frame bit did not invert");

  chk_status_reload: assert property (drive && clk_rise && ce_i && // R13
    q.txcnt == ctl_port_pkg::LAST_BIT && q.mode == ctl_port_pkg::MODE_RD_STAT |=>
    q.tx == $past(status_now))
    else $error("status not refreshed between reads");

  chk_status_layout: assert property (status_word_o.unused == 3'h0 && // R14
    ($past(input_locked_i) || status_word_o.subprocess == 2'h0))
    else $error("status layout broken");

  cov_init_done: cover property ($rose(run));
  cov_continue: cover property (item_cont_o);
  cov_status_read: cover property (drive && q.mode == ctl_port_pkg::MODE_RD_STAT && clk_rise);
  cov_item_read: cover property (item_rd_o ##[1:1000] item_ack_i);

endmodule : ctl_port_core

// [shared/ctl_port_pkg.sv]
// Shared constants and types of the three-wire control port slave.
// Assumes the control port core and its link receiver are both built from it.
// Notes on behaviour
// [R1] Host opens each access with an 8-bit address while select is low.
// [R2] Data bytes go with select high; unaddressed devices ignore them until next address.
// [R3] Address bits 7 to 2 equal 011000 select us; bits 1 and 0 are the mode.
// [R4] Mode 00 write item, 01 read item, 10 write control, 11 read status; held.
// [R5] An item transfer starts with its control byte, then whole bytes follow.
// [R6] Host checks port ready before each item byte; clear means not accepting yet.
// [R7] During device reset select stays low, clock high, line released, no transfers.
// [R8] After reset a select high-low pulse with clock high initialises the port.
// [R9] First transfer to us is a control write or status read, never item data.
// [R10] Control words need no status check; each replaces the previous one.
// [R11] Codes 0..3,5,6 name items, 7 continues; 4 and 8 to 255 are reserved.
// [R12] Continue resumes the item interrupted by a coefficient write; others start afresh.
// [R13] Status may be read repeatedly and is refreshed between reads.
// [R14] Status bit 0 is port ready, bit 1 input locked, bits 7..5 decode state.
// [R15] Status bit 7 toggles per new frame; decode bits valid only when locked.
// [R16] Status bits 6..5: 0 header, 1 allocation, 2 scale factors, 3 samples.
// [R17] Subprocess 3 lasts at least half (layer I) or five sixths (layer II) frame.
// [R18] Reset clears port ready; it sets only after the first control byte.
// [R19] Port ready is shown on the data line so the host can poll it.
// [R20] Ancillary data and both headers become valid after subprocess 0.
// [R21] Allocation flag is valid from after subprocess 1 through next subprocess 0.
// [R22] Decode failure flag valid after subprocess 2 through next subprocess 0.
// [R23] Host leaves the port alone while device reset is active.
// [R24] Data line is driven only when addressed in a read mode with select high.

package ctl_port_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Addressing and control codes.
  localparam logic [5:0] DEV_ADDR_PATTERN = 6'h18;
  localparam logic [7:0] CODE_SETTINGS = 8'h00;
  localparam logic [7:0] CODE_DEC_HDR = 8'h01;
  localparam logic [7:0] CODE_USED_HDR = 8'h02;
  localparam logic [7:0] CODE_ERR_REPORT = 8'h03;
  localparam logic [7:0] CODE_RESERVED = 8'h04;
  localparam logic [7:0] CODE_ANC_DATA = 8'h05;
  localparam logic [7:0] CODE_COEF_WRITE = 8'h06;
  localparam logic [7:0] CODE_CONTINUE = 8'h07;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and counts.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic BIT_CLK_IDLE = 1'b1;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] SUB_HEADER = 2'h0;
  localparam logic [1:0] SUB_ALLOC = 2'h1;
  localparam logic [1:0] SUB_SCALE = 2'h2;
  localparam logic [1:0] SUB_SAMPLES = 2'h3;

  typedef enum logic [1:0] {
    MODE_WR_ITEM = 2'h0,
    MODE_RD_ITEM = 2'h1,
    MODE_WR_CTRL = 2'h2,
    MODE_RD_STAT = 2'h3
  } mode_t;

  typedef enum logic [1:0] {INIT_WAIT_HI, INIT_WAIT_LO, INIT_RUN} init_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic sel;
    logic [7:0] data;
  } link_byte_t;

  typedef struct packed {
    logic frame_toggle;
    logic [1:0] subprocess;
    logic [2:0] unused;
    logic input_locked;
    logic port_ready;
  } status_t;

  typedef struct packed {
    logic anc;
    logic hdr;
    logic alloc_ok;
    logic decode_fail;
  } valid_t;

endpackage : ctl_port_pkg

// [verilog/ctl_link_rx.sv]
// Link-side byte receiver, clocked by the host's bit clock.
// Assumes an asynchronous clear from the core domain realigns bytes between phases.
`timescale 1ns/1ps

module ctl_link_rx (
  // Link clock and clear
  input wire logic link_clk_i,
  input wire logic link_clr_i,
  // Bus pins
  input wire logic sd_i,
  input wire logic sel_i,
  // Byte towards the core
  output ctl_port_pkg::link_byte_t byte_o,
  output logic toggle_o
);

  typedef struct packed {
    logic [2:0] cnt;
    logic [7:0] sh;
    ctl_port_pkg::link_byte_t byte_r;
    logic tog;
  } rx_t;

  rx_t q;
  rx_t d;

  // Bits arrive least significant first; the byte is handed over by a toggle
  // so the core can take it long after this clock has stopped.
  always_comb begin
    d = q;
    d.sh = {sd_i, q.sh[7:1]};
    d.cnt = q.cnt + 3'h1;
    if (q.cnt == ctl_port_pkg::LAST_BIT) begin
      d.byte_r = '{sel: sel_i, data: d.sh};
      d.tog = ~q.tog;
    end
  end

  always_ff @(posedge link_clk_i or posedge link_clr_i) begin
    if (link_clr_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign byte_o = q.byte_r;
  assign toggle_o = q.tog;

  chk_byte_toggle: assert property (@(posedge link_clk_i) disable iff (link_clr_i) // R1
    $changed(q.tog) |-> $past(q.cnt) == ctl_port_pkg::LAST_BIT)
    else $error("byte toggle without eight bits");

endmodule : ctl_link_rx

// [test/ctl_host_model.sv]
// Behavioural host master for the three-wire control bus.
// Assumes the bench resolves the shared data wire from both drivers' enables.
`timescale 1ns/1ps

module ctl_host_model (
  // Bus pins
  output logic bit_clk_o,
  output logic sel_o,
  output logic data_o,
  output logic data_oe_o,
  // Resolved data wire
  input wire logic line_i
);
  localparam time HALF = 40ns;

  initial begin
    bit_clk_o = 1'b1;
    sel_o = 1'b0;
    data_o = 1'b0;
    data_oe_o = 1'b0;
  end

  //////////////////////////////////////////////////////////////
  // Select goes high then low with the clock parked high.
  task automatic init_pulse();
    #(HALF) sel_o = 1'b1;
    #(HALF) sel_o = 1'b0;
    #(HALF);
  endtask : init_pulse

  // Select settles a half period before the first falling edge, so the
  // receiver's bit counter is cleared before the byte starts.
  task automatic xfer(input logic sel, input logic drive, input logic [7:0] tx,
                      output logic [7:0] rx);
    sel_o = sel;
    data_oe_o = drive;
    #(HALF);
    for (int i = 0; i < 8; i++) begin
      bit_clk_o = 1'b0;
      data_o = tx[i];
      #(HALF);
      rx[i] = line_i;
      bit_clk_o = 1'b1;
      #(HALF);
    end
    data_oe_o = 1'b0;
  endtask : xfer
endmodule : ctl_host_model

// [test/ctl_port_core_bench.sv]
// Self-checking bench for the control port slave.
// Assumes the host model drives the bus and the bench drives the decoder side.
`timescale 1ns/1ps

module ctl_port_core_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic locked = 1'b1;
  logic [1:0] sub = 2'h2;
  logic frame_start = 1'b0;
  logic [7:0] rd_data = 8'h3c;
  logic ack = 1'b0;
  logic float_q = 1'b0;
  logic bclk, sel, host_d, host_oe, dev_d, dev_oe, start, cont, wr, rd, ready;
  logic [7:0] code, wr_data, ctrl, rx;
  ctl_port_pkg::status_t stat;
  ctl_port_pkg::valid_t valid;
  wire logic sd_line = dev_oe ? dev_d : (host_oe ? host_d : float_q);
  int err_count = 0;
  int checked = 0;
  int n_start = 0;
  int n_cont = 0;
  int n_wr = 0;
  int n_rd = 0;
  logic [7:0] codes [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h04,
                             8'h08, 8'hff};

  always #2 clk_i = ~clk_i;

  // A released wire must not keep its last level, so it wanders instead.
  always @(posedge clk_i) begin
    float_q <= ~float_q;
    n_start <= n_start + int'(start === 1'b1);
    n_cont <= n_cont + int'(cont === 1'b1);
    n_wr <= n_wr + int'(wr === 1'b1);
    n_rd <= n_rd + int'(rd === 1'b1);
  end

  ctl_host_model ctl_host_model_inst (
    .bit_clk_o(bclk),
    .sel_o(sel),
    .data_o(host_d),
    .data_oe_o(host_oe),
    .line_i(sd_line)
  );

  ctl_port_core ctl_port_core_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(1'b1),
    .ctl_bit_clock_i(bclk),
    .ctl_addr_data_select_i(sel),
    .ctl_serial_data_i(sd_line),
    .ctl_serial_data_o(dev_d),
    .ctl_serial_data_oe_o(dev_oe),
    .input_locked_i(locked),
    .subprocess_i(sub),
    .frame_start_i(frame_start),
    .item_rd_data_i(rd_data),
    .item_ack_i(ack),
    .item_start_o(start),
    .item_cont_o(cont),
    .item_code_o(code),
    .item_wr_o(wr),
    .item_wr_data_o(wr_data),
    .item_rd_o(rd),
    .control_word_o(ctrl),
    .status_word_o(stat),
    .port_ready_o(ready),
    .item_valid_o(valid)
  );

  //////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic send(input logic s, input logic [7:0] b);
    logic [7:0] dummy;
    ctl_host_model_inst.xfer(s, 1'b1, b, dummy);
  endtask : send

  task automatic get(output logic [7:0] b);
    ctl_host_model_inst.xfer(1'b1, 1'b0, 8'h00, b);
  endtask : get

  task automatic pulse_ack();
    @(posedge clk_i) #1 ack = 1'b1;
    @(posedge clk_i) #1 ack = 1'b0;
  endtask : pulse_ack

  //////////////////////////////////////////////////////////////
  initial begin
    #100us;
    err_count++;
    give_verdict();
  end

  initial begin
    int s0;
    int c0;
    repeat (6) @(posedge clk_i);
    #1 rst_i = 1'b0;
    check("oe after reset", {7'h0, dev_oe}, 8'h00);
    check("ready after reset", {7'h0, stat.port_ready}, 8'h00);
    check("control after reset", ctrl, 8'h00);
    ctl_host_model_inst.init_pulse();
    // Another device's address, then a data byte that is not ours.
    send(1'b0, 8'h42);
    send(1'b1, 8'h07);
    check("control ignored", ctrl, 8'h00);
    check("no start", n_start[7:0], 8'h00);
    @(posedge clk_i) #1 frame_start = 1'b1;
    @(posedge clk_i) #1 frame_start = 1'b0;
    send(1'b0, 8'h63);
    check("oe in address phase", {7'h0, dev_oe}, 8'h00);
    get(rx);
    check("status first", rx & 8'he3, 8'hc2);
    check("oe in read", {7'h0, dev_oe}, 8'h01);
    @(posedge clk_i) #1 sub = 2'h1;
    get(rx);
    get(rx);
    check("status again", rx & 8'he3, 8'ha2);
    send(1'b0, 8'h62);
    foreach (codes[i]) begin
      s0 = n_start;
      c0 = n_cont;
      send(1'b1, codes[i]);
      check("control word", ctrl, codes[i]);
      check("start count", 8'(n_start - s0), {7'h0, codes[i] <= 8'h06 && codes[i] != 8'h04});
      check("cont count", 8'(n_cont - c0), {7'h0, codes[i] == 8'h07});
      if (codes[i] == 8'h07) begin
        check("resumed item", code, 8'h05);
      end
    end
    check("ready after control", {7'h0, stat.port_ready}, 8'h01);
    send(1'b0, 8'h63);
    get(rx);
    check("ready on line", {7'h0, rx[0]}, 8'h01);
    // Item write of the settings byte.
    send(1'b0, 8'h62);
    send(1'b1, 8'h00);
    send(1'b0, 8'h60);
    s0 = n_wr;
    send(1'b1, 8'ha5);
    check("item write data", wr_data, 8'ha5);
    check("item write count", 8'(n_wr - s0), 8'h01);
    check("ready after byte", {7'h0, stat.port_ready}, 8'h00);
    check("ready output", {7'h0, ready}, 8'h00);
    pulse_ack();
    for (int i = 0; i < 20 && stat.port_ready !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    check("ready after ack", {7'h0, stat.port_ready}, 8'h01);
    check("ready output", {7'h0, ready}, 8'h01);
    // Item read of a header byte.
    send(1'b0, 8'h62);
    send(1'b1, 8'h01);
    send(1'b0, 8'h61);
    s0 = n_rd;
    get(rx);
    check("item read data", rx, 8'h3c);
    check("item read count", 8'(n_rd - s0), 8'h01);
    // Validity and decode state over every subprocess, locked or not.
    for (int l = 0; l < 2; l++) begin
      for (int s = 0; s < 4; s++) begin
        @(posedge clk_i) #1 locked = l[0];
        sub = s[1:0];
        repeat (3) @(posedge clk_i);
        #1 check("valid", {4'h0, valid}, {4'h0, l[0] && s != 0, l[0] && s != 0,
               l[0] && s != 1, l[0] && (s == 3 || s == 0)});
        check("decode state", {6'h0, stat.subprocess}, l[0] ? 8'(s) : 8'h00);
      end
    end
    // A second reset in mid-run must bring the port back to its start-up state.
    send(1'b0, 8'h00);
    @(posedge clk_i) #1 rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    #1 rst_i = 1'b0;
    check("oe after reset", {7'h0, dev_oe}, 8'h00);
    check("ready after reset", {7'h0, ready}, 8'h00);
    check("control after reset", ctrl, 8'h00);
    ctl_host_model_inst.init_pulse();
    send(1'b0, 8'h63);
    get(rx);
    check("status after reset", rx & 8'he3, 8'h62);
    give_verdict();
  end
endmodule : ctl_port_core_bench
